// ===== hdl/flash_id_dev.sv
// Flash device end: power-down entry and release, ID readouts, write wait
//
// How it works
// [R01] Sample opcode and address on rising clock
// [R02] B9h then select high enters sleep
// [R03] B9h not ended at bit eight is dropped
// [R04] Asleep: only ABh recognised, rest ignored
// [R05] Reset always starts awake
// [R06] ABh then select high wakes after delay
// [R07] ABh plus three dummies streams device ID
// [R08] ABh with ID read wakes after the same 3 us delay as R06
// [R09] ABh while busy ignored entirely
// [R10] 90h address zero: maker then device
// [R11] 90h address one: device then maker
// [R12] 90h bytes alternate until select rises
// [R13] 9Fh gives maker, type, capacity bytes
// [R14] 4Bh with zero address, dummy, 64 bits
// [R15] Unique ID fixed, no command alters it
// [R16] Writes inhibited until power-up wait ends
// [R17] Host waits after supply before select
// [R18] ID byte values are design parameters
`timescale 1ns/1ps
module flash_id_dev
  import flash_id_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value [R18]
  parameter logic [7:0] MEM_TYPE_ID = 8'h40, // Arbitrary value
  parameter logic [7:0] CAPACITY_ID = 8'h14, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h13, // Arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter int CNT_W = 16,
  parameter int PUW_CYC = cyc_ceil(POWERUP_WRITE_WAIT_MIN_MS * 1.0e6)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_busy,
  flash_link_if.dev link,
  output logic o_awake,
  output logic o_sleeping,
  output logic o_write_ok
);
  // ****************************************
  // Constants at counter and timer width
  // ****************************************
  localparam logic [CNT_W-1:0] C_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] C_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] C_OP = CNT_W'(OP_BITS);
  localparam logic [CNT_W-1:0] C_WAKE_ID = CNT_W'(WAKE_ID_START);
  localparam logic [CNT_W-1:0] C_MFR_DEV = CNT_W'(MFR_DEV_START);
  localparam logic [CNT_W-1:0] C_IDENT = CNT_W'(IDENT_START);
  localparam logic [CNT_W-1:0] C_IDENT_LEN = CNT_W'(IDENT_BITS);
  localparam logic [CNT_W-1:0] C_UID = CNT_W'(UID_START);
  localparam logic [CNT_W-1:0] C_UID_LEN = CNT_W'(UID_BITS);
  localparam logic [TMR_W-1:0] T_ONE = TMR_W'(1);
  localparam logic [TMR_W-1:0] T_SLEEP = TMR_W'(SLEEP_ENTRY_CYC);
  localparam logic [TMR_W-1:0] T_WAKE = TMR_W'(WAKE_CYC);
  localparam logic [TMR_W-1:0] T_WAKE_ID = TMR_W'(WAKE_ID_CYC);
  localparam logic [TMR_W-1:0] T_PUW = TMR_W'(PUW_CYC);

  // MSB-first bit pick out of a left-aligned word
  function automatic logic pick(input logic [63:0] v, input logic [5:0] i);
    return v[6'd63 - i];
  endfunction

  // ****************************************
  // Link domain: frame capture
  // ****************************************
  logic armed_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [31:0] sreg_q;
  logic [31:0] sreg_d;
  logic [7:0] op_q;
  logic swap_q;
  logic addr_hi_zero_q;
  logic sleep_s1_q;
  logic sleep_s2_q;
  logic busy_s1_q;
  logic busy_s2_q;
  logic awake_q;
  wire arm_set = link.cs_n | ~i_rst_n;

  // Select high rearms the counter; the counter itself is kept so the
  // reference domain can read the finished frame while the clock stands
  always_ff @(posedge link.sclk or posedge arm_set) begin
    if (arm_set) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= 1'b0;
    end
  end

  assign cnt_d = armed_q ? C_ONE : ((cnt_q == C_MAX) ? cnt_q : cnt_q + C_ONE);
  assign sreg_d = {sreg_q[30:0], link.serial_in}; // [R01]

  always_ff @(posedge link.sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      sreg_q <= '0;
      op_q <= 8'h00;
      swap_q <= 1'b0;
      addr_hi_zero_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d; // [R01]
      sreg_q <= sreg_d;
      if (cnt_d == C_OP) begin
        op_q <= sreg_d[7:0]; // [R01]
      end
      if (cnt_d == C_MFR_DEV) begin
        swap_q <= sreg_d[0]; // [R11]
        addr_hi_zero_q <= (sreg_d[23:1] == 23'h000000);
      end
    end
  end

  // Sleep and busy levels settle on the first two edges of a frame,
  // long before the opcode is complete
  always_ff @(posedge link.sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      sleep_s1_q <= ~awake_q;
      sleep_s2_q <= sleep_s1_q;
      busy_s1_q <= i_busy;
      busy_s2_q <= busy_s1_q;
    end
  end

  // ****************************************
  // Link domain: readout
  // ****************************************
  logic so_q;
  logic oe_q;
  wire is_wake = (op_q == WAKE_ID_CMD);
  wire is_mfr_dev = (op_q == MFR_DEV_CMD);
  wire is_ident = (op_q == IDENT_READ_CMD);
  wire is_uid = (op_q == UNIQUE_ID_CMD);
  wire allowed = ~busy_s2_q & (~sleep_s2_q | is_wake); // [R04]
  wire [CNT_W-1:0] idx_wake = cnt_q - C_WAKE_ID;
  wire [CNT_W-1:0] idx_md = cnt_q - C_MFR_DEV;
  wire [CNT_W-1:0] idx_ident = cnt_q - C_IDENT;
  wire [CNT_W-1:0] idx_uid = cnt_q - C_UID;
  wire run_wake = is_wake & ~busy_s2_q & (cnt_q >= C_WAKE_ID); // [R07] [R09]
  wire run_md = is_mfr_dev & allowed & addr_hi_zero_q & (cnt_q >= C_MFR_DEV); // [R10]
  wire run_ident = is_ident & allowed & (cnt_q >= C_IDENT) & (idx_ident < C_IDENT_LEN);
  wire run_uid = is_uid & allowed & (cnt_q >= C_UID) & (idx_uid < C_UID_LEN); // [R14]
  wire md_second = idx_md[3] ^ swap_q; // [R11] [R12]
  wire [7:0] md_byte = md_second ? DEVICE_ID : MFR_ID;
  wire bit_wake = pick({DEVICE_ID, 56'h0}, {3'b000, idx_wake[2:0]}); // [R07]
  wire bit_md = pick({md_byte, 56'h0}, {3'b000, idx_md[2:0]});
  wire bit_ident = pick({MFR_ID, MEM_TYPE_ID, CAPACITY_ID, 40'h0}, idx_ident[5:0]); // [R13]
  wire bit_uid = pick(UNIQUE_ID, idx_uid[5:0]); // [R15]
  wire drive_d = run_wake | run_md | run_ident | run_uid;
  wire bit_d = (run_wake & bit_wake) | (run_md & bit_md)
             | (run_ident & bit_ident) | (run_uid & bit_uid);

  // Output changes on falling edges and lets go as soon as select rises
  always_ff @(negedge link.sclk or posedge arm_set) begin
    if (arm_set) begin
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      so_q <= bit_d; // [R07] [R10] [R13] [R14]
      oe_q <= drive_d;
    end
  end
  assign link.serial_out = so_q;
  assign link.serial_out_oe = oe_q;

  // ****************************************
  // Reference domain: select edge
  // ****************************************
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else if (i_clk_en) begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end
  wire frame_end = cs_s2_q & ~cs_s3_q;
  // Frame words are still while select is high, so reading them here is safe
  wire cmd_sleep = (op_q == DEEP_SLEEP_CMD) & (cnt_q == C_OP); // [R02] [R03]
  wire cmd_wake = is_wake & (cnt_q >= C_OP);
  wire wake_long = (cnt_q != C_OP);

  // ****************************************
  // Reference domain: power state
  // ****************************************
  pwr_state_t state_q;
  pwr_state_t state_d;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] tmr_d;
  wire tmr_done = (tmr_q == T_ONE);

  always_comb begin
    state_d = state_q;
    tmr_d = tmr_done ? tmr_q : tmr_q - T_ONE;
    case (state_q)
      PWR_AWAKE: begin
        if (frame_end & cmd_sleep) begin
          state_d = PWR_ENTERING; // [R02]
          tmr_d = T_SLEEP;
        end
      end
      PWR_ENTERING: begin
        if (tmr_done) begin
          state_d = PWR_ASLEEP; // [R02]
        end
      end
      PWR_ASLEEP: begin
        if (frame_end & cmd_wake & ~i_busy) begin
          state_d = PWR_WAKING; // [R06] [R09]
          tmr_d = wake_long ? T_WAKE_ID : T_WAKE; // [R08]
        end
      end
      PWR_WAKING: begin
        if (tmr_done) begin
          state_d = PWR_AWAKE; // [R06] [R08]
        end
      end
      default: begin
        state_d = PWR_AWAKE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= PWR_AWAKE; // [R05]
      tmr_q <= T_ONE;
      awake_q <= 1'b1;
      o_sleeping <= 1'b0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      awake_q <= (state_d == PWR_AWAKE); // [R04]
      o_sleeping <= (state_d == PWR_ASLEEP);
    end
  end
  assign o_awake = awake_q;

  // ****************************************
  // Reference domain: power-up write wait
  // ****************************************
  logic [TMR_W-1:0] puw_q;
  logic write_ok_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      puw_q <= T_PUW;
      write_ok_q <= 1'b0;
    end else if (i_clk_en) begin
      if (puw_q != T_ONE) begin
        puw_q <= puw_q - T_ONE;
      end
      write_ok_q <= (puw_q == T_ONE); // [R16]
    end
  end
  assign o_write_ok = write_ok_q;
endmodule

// ===== hdl/flash_id_host.sv
// Host controller end: frames ID and power-down commands over the link
`timescale 1ns/1ps
module flash_id_host
  import flash_id_pkg::*;
#(
  parameter int HALF_DIV = 4,
  parameter int SUPPLY_WAIT_CYC = cyc_ceil(SUPPLY_TO_SELECT_WAIT_MS * 1.0e6),
  parameter int PUW_WAIT_CYC = cyc_ceil(POWERUP_WRITE_WAIT_MAX_MS * 1.0e6)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_op,
  input wire logic [23:0] i_cmd_addr,
  input wire logic [3:0] i_cmd_rd_bytes,
  output logic o_cmd_ready,
  output logic [63:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_write_ok,
  flash_link_if.host link
);
  localparam logic [TMR_W-1:0] T_ONE = TMR_W'(1);
  localparam logic [7:0] HALF_RELOAD = 8'(HALF_DIV - 1);

  // Bits sent before any readout; sleep is exactly one opcode byte
  function automatic logic [7:0] tx_len(input logic [7:0] op, input logic rd);
    case (op)
      DEEP_SLEEP_CMD: tx_len = 8'(OP_BITS); // [R03]
      IDENT_READ_CMD: tx_len = 8'(OP_BITS);
      WAKE_ID_CMD: tx_len = rd ? 8'(WAKE_ID_START) : 8'(OP_BITS);
      UNIQUE_ID_CMD: tx_len = 8'(UID_START); // [R14]
      default: tx_len = 8'(MFR_DEV_START);
    endcase
  endfunction
  function automatic logic [TMR_W-1:0] gap_len(input logic [7:0] op, input logic rd);
    case (op)
      DEEP_SLEEP_CMD: gap_len = TMR_W'(HOST_SLEEP_CYC);
      WAKE_ID_CMD: gap_len = rd ? TMR_W'(HOST_WAKE_ID_CYC) : TMR_W'(HOST_WAKE_CYC); // [R06] [R08]
      default: gap_len = TMR_W'(HOST_MIN_GAP_CYC);
    endcase
  endfunction

  host_state_t state_q;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] puw_q;
  logic [7:0] half_q;
  logic [7:0] bit_q;
  logic [7:0] len_q;
  logic [7:0] tot_q;
  logic [FRAME_W-1:0] tx_q;
  logic [TMR_W-1:0] gap_q;
  logic sclk_q;
  logic cs_n_q;
  logic si_q;
  logic so_s1_q;
  logic so_s2_q;
  wire rd_any = (i_cmd_rd_bytes != 4'h0);
  wire [FRAME_W-1:0] word = {i_cmd_op, i_cmd_addr, 8'h00}; // [R14]
  wire half_tick = (half_q == 8'h00);
  wire last_fall = half_tick & sclk_q & (bit_q == tot_q);

  // ****************************************
  // Frame engine
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= H_POWERUP;
      tmr_q <= TMR_W'(SUPPLY_WAIT_CYC);
      half_q <= 8'h00;
      bit_q <= 8'h00;
      len_q <= 8'h00;
      tot_q <= 8'h00;
      tx_q <= '0;
      gap_q <= T_ONE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      si_q <= 1'b0;
      so_s1_q <= 1'b0;
      so_s2_q <= 1'b0;
      o_rd_data <= 64'h0;
      o_rd_valid <= 1'b0;
      o_cmd_ready <= 1'b0;
    end else if (i_clk_en) begin
      so_s1_q <= link.serial_out;
      so_s2_q <= so_s1_q;
      o_rd_valid <= 1'b0;
      half_q <= half_tick ? HALF_RELOAD : half_q - 8'h01;
      case (state_q)
        H_POWERUP: begin
          tmr_q <= tmr_q - T_ONE;
          if (tmr_q == T_ONE) begin
            state_q <= H_IDLE; // [R17]
            o_cmd_ready <= 1'b1;
          end
        end
        H_IDLE: begin
          if (i_cmd_valid) begin
            state_q <= H_SHIFT;
            o_cmd_ready <= 1'b0;
            cs_n_q <= 1'b0;
            si_q <= word[FRAME_W-1];
            tx_q <= {word[FRAME_W-2:0], 1'b0};
            len_q <= tx_len(i_cmd_op, rd_any);
            tot_q <= tx_len(i_cmd_op, rd_any) + {1'b0, i_cmd_rd_bytes, 3'b000};
            gap_q <= gap_len(i_cmd_op, rd_any);
            bit_q <= 8'h00;
            half_q <= HALF_RELOAD;
            o_rd_data <= 64'h0;
          end
        end
        H_SHIFT: begin
          if (last_fall) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1; // [R03]
            tmr_q <= gap_q;
            state_q <= H_GAP;
            o_rd_valid <= 1'b1;
          end else if (half_tick & ~sclk_q) begin
            sclk_q <= 1'b1;
            bit_q <= bit_q + 8'h01;
            if (bit_q >= len_q) begin
              o_rd_data <= {o_rd_data[62:0], so_s2_q};
            end
          end else if (half_tick) begin
            sclk_q <= 1'b0;
            si_q <= tx_q[FRAME_W-1];
            tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
          end
        end
        H_GAP: begin
          // Select held high for the whole wake delay
          tmr_q <= tmr_q - T_ONE;
          if (tmr_q == T_ONE) begin
            state_q <= H_IDLE; // [R06] [R08]
            o_cmd_ready <= 1'b1;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.serial_in = si_q;

  // ****************************************
  // Write permission after power-up
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      puw_q <= TMR_W'(PUW_WAIT_CYC);
      o_write_ok <= 1'b0;
    end else if (i_clk_en) begin
      if (puw_q != T_ONE) begin
        puw_q <= puw_q - T_ONE;
      end
      o_write_ok <= (puw_q == T_ONE); // [R16]
    end
  end
endmodule

// ===== hdl/flash_id_pkg.sv
// Shared constants and types for the flash ID and power-down link
package flash_id_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] DEEP_SLEEP_CMD = 8'hb9;
  localparam logic [7:0] WAKE_ID_CMD = 8'hab;
  localparam logic [7:0] MFR_DEV_CMD = 8'h90;
  localparam logic [7:0] IDENT_READ_CMD = 8'h9f;
  localparam logic [7:0] UNIQUE_ID_CMD = 8'h4b;
  // ****************************************
  // Frame layout in bits
  // ****************************************
  localparam int OP_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int DUMMY_BITS = 8;
  localparam int WAKE_ID_START = OP_BITS + 3 * DUMMY_BITS;
  localparam int MFR_DEV_START = OP_BITS + ADDR_BITS;
  localparam int IDENT_START = OP_BITS;
  localparam int IDENT_BITS = 24;
  localparam int UID_START = OP_BITS + ADDR_BITS + DUMMY_BITS;
  localparam int UID_BITS = 64;
  localparam int FRAME_W = 40;
  localparam int TMR_W = 32;
  // ****************************************
  // Timing
  // ****************************************
  localparam real REF_PERIOD_NS = 10.0;
  localparam real SLEEP_ENTRY_DELAY_US = 3.0;
  localparam real WAKE_DELAY_US = 3.0;
  localparam real WAKE_WITH_ID_DELAY_US = 3.0;
  localparam real POWERUP_WRITE_WAIT_MIN_MS = 1.0;
  localparam real POWERUP_WRITE_WAIT_MAX_MS = 10.0;
  localparam real SUPPLY_TO_SELECT_WAIT_MS = 0.3;
  function automatic int cyc_floor(real t_ns);
    int n;
    n = $rtoi(t_ns / REF_PERIOD_NS);
    return (n < 1) ? 1 : n;
  endfunction
  function automatic int cyc_ceil(real t_ns);
    int n;
    n = $rtoi(t_ns / REF_PERIOD_NS);
    if (n * REF_PERIOD_NS < t_ns) n = n + 1;
    return (n < 1) ? 1 : n;
  endfunction
  localparam int SLEEP_ENTRY_CYC = cyc_floor(SLEEP_ENTRY_DELAY_US * 1000.0);
  localparam int WAKE_CYC = cyc_floor(WAKE_DELAY_US * 1000.0);
  localparam int WAKE_ID_CYC = cyc_floor(WAKE_WITH_ID_DELAY_US * 1000.0);
  localparam int HOST_SLEEP_CYC = cyc_ceil(SLEEP_ENTRY_DELAY_US * 1000.0);
  localparam int HOST_WAKE_CYC = cyc_ceil(WAKE_DELAY_US * 1000.0);
  localparam int HOST_WAKE_ID_CYC = cyc_ceil(WAKE_WITH_ID_DELAY_US * 1000.0);
  localparam int HOST_MIN_GAP_CYC = 8;
  // ****************************************
  // States
  // ****************************************
  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b00,
    PWR_ENTERING = 2'b01,
    PWR_ASLEEP = 2'b11,
    PWR_WAKING = 2'b10
  } pwr_state_t;
  typedef enum logic [1:0] {
    H_POWERUP = 2'b00,
    H_IDLE = 2'b01,
    H_SHIFT = 2'b11,
    H_GAP = 2'b10
  } host_state_t;
endpackage

// ===== hdl/flash_link_if.sv
// Serial link between the host controller and the flash ID logic
`timescale 1ns/1ps
interface flash_link_if;
  logic sclk;
  logic cs_n;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  modport host (
    output sclk,
    output cs_n,
    output serial_in,
    input serial_out,
    input serial_out_oe
  );
  modport dev (
    input sclk,
    input cs_n,
    input serial_in,
    output serial_out,
    output serial_out_oe
  );
endinterface

// ===== verif/flash_id_monitor.sv
// Link and power-state checker for the flash ID link
`timescale 1ns/1ps
module flash_id_monitor
  import flash_id_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic o_awake,
  input wire logic o_sleeping
);
  // ****************************************
  // Frame tracking
  // ****************************************
  logic sclk_q;
  logic [7:0] cnt_q;
  logic [7:0] op_q;
  wire sclk_rise = sclk && !sclk_q;
  wire [7:0] start_w = (op_q == IDENT_READ_CMD) ? 8'h08 :
                       (op_q == UNIQUE_ID_CMD) ? 8'h28 : 8'h20;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q <= 1'b0;
      cnt_q <= 8'h00;
      op_q <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) cnt_q <= 8'h00;
      else if (sclk_rise && cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
      // Opcode kept past the frame end for the power checks
      if (!cs_n && sclk_rise && cnt_q < 8'h08) op_q <= {op_q[6:0], serial_in};
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence sleep_frame_s;
    $rose(cs_n) && op_q == DEEP_SLEEP_CMD && o_awake;
  endsequence
  sequence entering_s;
    $fell(o_awake) ##0 !o_sleeping;
  endsequence
  AST_IDLE_CLK: assert property (cs_n |-> !sclk)
    else $error("serial clock moved while deselected");
  AST_OE_OFF: assert property (cs_n |-> !serial_out_oe)
    else $error("output enabled while deselected");
  AST_START_AWAKE: assert property ($rose(i_rst_n) |-> o_awake && !o_sleeping)
    else $error("not awake after reset");
  AST_SLEEP_TAKEN: assert property (sleep_frame_s ##0 cnt_q == 8'h08 |-> ##[1:6] !o_awake)
    else $error("eight-bit sleep command not taken");
  AST_SLEEP_DROPPED: assert property (sleep_frame_s ##0 cnt_q != 8'h08 |-> ##1 o_awake [*8])
    else $error("overlong sleep command taken");
  AST_SLEEP_DELAY: assert property (entering_s |-> ##[1:310] o_sleeping)
    else $error("sleep entry too slow");
  AST_WAKE_DELAY: assert property ($fell(o_sleeping) |-> !o_awake ##[1:310] o_awake)
    else $error("wake too slow");
  AST_ASLEEP_QUIET: assert property (o_sleeping && serial_out_oe |-> op_q == WAKE_ID_CMD)
    else $error("output while asleep without wake command");
  AST_OUT_START: assert property ($rose(serial_out_oe) |-> cnt_q == start_w)
    else $error("readout started at wrong bit");
  AST_OUT_STANDS: assert property (serial_out_oe && $past(serial_out_oe) && !$fell(sclk)
    |-> $stable(serial_out))
    else $error("output changed away from falling clock");
  AST_IDENT_LEN: assert property ($fell(serial_out_oe) && !cs_n && op_q == IDENT_READ_CMD
    |-> cnt_q == 8'h20)
    else $error("identification readout wrong length");
endmodule

// ===== verif/flash_powerdown_and_id_commands_tb.sv
// Testbench joining the host and device ends of the flash ID link
`timescale 1ns/1ps
module flash_powerdown_and_id_commands_tb;
  import flash_id_pkg::*;
  localparam logic [7:0] MFR = 8'h5a; // Arbitrary value
  localparam logic [7:0] MEMT = 8'h40; // Arbitrary value
  localparam logic [7:0] CAP = 8'h14; // Arbitrary value
  localparam logic [7:0] DEV = 8'h13; // Arbitrary value
  localparam logic [63:0] UID = 64'hfeed_0bad_1357_2468; // Arbitrary value
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_busy = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic [7:0] i_cmd_op = 8'h00;
  logic [23:0] i_cmd_addr = 24'h000000;
  logic [3:0] i_cmd_rd_bytes = 4'h0;
  logic cmd_ready, rd_valid, host_wok, awake, sleeping, dev_wok;
  logic [63:0] rd_data;
  logic [63:0] d;
  int fail_count = 0;
  int n_compared = 0;
  flash_link_if flash_link_if_i();
  flash_id_host #(.SUPPLY_WAIT_CYC(20), .PUW_WAIT_CYC(50)) flash_id_host_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
    .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
    .i_cmd_rd_bytes(i_cmd_rd_bytes), .o_cmd_ready(cmd_ready), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_write_ok(host_wok), .link(flash_link_if_i));
  flash_id_dev #(.MFR_ID(MFR), .MEM_TYPE_ID(MEMT), .CAPACITY_ID(CAP), .DEVICE_ID(DEV),
    .UNIQUE_ID(UID), .PUW_CYC(40)) flash_id_dev_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1), .i_busy(i_busy),
    .link(flash_link_if_i), .o_awake(awake), .o_sleeping(sleeping), .o_write_ok(dev_wok));
  flash_id_monitor flash_id_monitor_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .sclk(flash_link_if_i.sclk),
    .cs_n(flash_link_if_i.cs_n), .serial_in(flash_link_if_i.serial_in),
    .serial_out(flash_link_if_i.serial_out), .serial_out_oe(flash_link_if_i.serial_out_oe),
    .o_awake(awake), .o_sleeping(sleeping));
  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic timed_out();
    fail_count++;
    $display("mismatch handshake timeout");
    complete_run();
  endtask
  // Waits on the falling edge so settled levels are read
  task automatic cmd(input logic [7:0] op, input logic [23:0] addr, input logic [3:0] nb);
    int n;
    n = 0;
    @(negedge i_ref_clk);
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 2000) timed_out();
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1;
    i_cmd_op <= op;
    i_cmd_addr <= addr;
    i_cmd_rd_bytes <= nb;
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    n = 0;
    @(negedge i_ref_clk);
    while (rd_valid !== 1'b1 && n < 2000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 2000) timed_out();
    d = rd_data;
  endtask
  task automatic settle(input int cyc);
    repeat (cyc + 10) @(negedge i_ref_clk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(negedge i_ref_clk);
    check("awake", awake, 1);
    check("sleeping", sleeping, 0);
    check("dev write ok early", dev_wok, 0);
    check("host write ok early", host_wok, 0);
    cmd(IDENT_READ_CMD, 24'h000000, 4'h4);
    check("ident", d[31:8], {MFR, MEMT, CAP});
    check("ident tail", d[7:0], 0);
    for (int a = 0; a < 2; a++) begin
      cmd(MFR_DEV_CMD, 24'(a), 4'h4);
      check("mfr dev", d[31:0], (a == 0) ? {MFR, DEV, MFR, DEV} : {DEV, MFR, DEV, MFR});
    end
    cmd(UNIQUE_ID_CMD, 24'h000000, 4'h8);
    check("unique id", d, UID);
    cmd(WAKE_ID_CMD, 24'h000000, 4'h2);
    check("wake id", d[15:0], {DEV, DEV});
    cmd(UNIQUE_ID_CMD, 24'h000000, 4'h8);
    check("unique id again", d, UID);
    check("dev write ok", dev_wok, 1);
    check("host write ok", host_wok, 1);
    // Sleep opcode with extra clocks must be discarded
    cmd(DEEP_SLEEP_CMD, 24'h000000, 4'h1);
    settle(SLEEP_ENTRY_CYC);
    check("awake after long sleep frame", awake, 1);
    cmd(DEEP_SLEEP_CMD, 24'h000000, 4'h0);
    settle(SLEEP_ENTRY_CYC);
    check("asleep", sleeping, 1);
    check("not awake", awake, 0);
    cmd(IDENT_READ_CMD, 24'h000000, 4'h3);
    check("asleep after ident", sleeping, 1);
    check("ident ignored asleep", d[23:0], 0);
    // Inputs move on the rising edge only
    @(posedge i_ref_clk);
    i_busy <= 1'b1;
    cmd(WAKE_ID_CMD, 24'h000000, 4'h0);
    settle(WAKE_CYC);
    check("asleep after busy wake", sleeping, 1);
    @(posedge i_ref_clk);
    i_busy <= 1'b0;
    cmd(WAKE_ID_CMD, 24'h000000, 4'h0);
    settle(WAKE_CYC);
    check("awake after wake", awake, 1);
    cmd(DEEP_SLEEP_CMD, 24'h000000, 4'h0);
    settle(SLEEP_ENTRY_CYC);
    check("asleep again", sleeping, 1);
    cmd(WAKE_ID_CMD, 24'h000000, 4'h1);
    check("wake id from sleep", d[7:0], DEV);
    settle(WAKE_ID_CYC);
    check("awake after id wake", awake, 1);
    cmd(IDENT_READ_CMD, 24'h000000, 4'h3);
    check("ident after wake", d[23:0], {MFR, MEMT, CAP});
    complete_run();
  end
endmodule
